// ---- design/sfe_consts.svh ----
// Constants for the serial flash erase/program command block
`ifndef SFE_CONSTS_SVH
`define SFE_CONSTS_SVH
`define SFE_OP_WREN 8'h06
`define SFE_OP_WRDI 8'h04
`define SFE_OP_BE4 8'h20
`define SFE_OP_BE32 8'h52
`define SFE_OP_BE64 8'hD8
`define SFE_OP_CE_A 8'h60
`define SFE_OP_CE_B 8'hC7
`define SFE_OP_PP 8'h02
`define SFE_OP_SUSP 8'h75
`define SFE_CMD_BYTES 10'h001
`define SFE_ADDR_END 10'h004
`define SFE_DATA_FIRST 10'h005
`define SFE_NB_MAX 10'h3FF
`define SFE_MASK_4K 24'hFFF000
`define SFE_MASK_32K 24'hFF8000
`define SFE_MASK_64K 24'hFF0000
`define SFE_BUSY_BIT 0
`define SFE_WEL_BIT 1
`define SFE_BP_LSB 2
`define SFE_EE_BIT 1
`define SFE_PE_BIT 0
`define SFE_CLK_MHZ 125
`define SFE_T_BLKE_US 50
`define SFE_T_CHPE_US 400
`define SFE_T_PP_US 4
`define SFE_T_BP_US 1
`define SFE_PAGE_LAST 9'h100
`endif

// ---- design/sfe_pkg.sv ----
// Types for the serial flash erase/program command block
package sfe_pkg;
  typedef enum logic [1:0] {SFE_IDLE = 2'b00, SFE_ERASE = 2'b01, SFE_PROG = 2'b10} sfe_state_t;
  typedef enum logic [1:0] {SFE_K4 = 2'b00, SFE_K32 = 2'b01, SFE_K64 = 2'b10, SFE_CHIP = 2'b11} sfe_kind_t;
endpackage

// ---- design/sfe_top.sv ----
// Serial flash erase/program command sequencer with data FIFO
`timescale 1ns/100ps
`include "sfe_consts.svh"

module sfe_fifo #(
  parameter int unsigned WIDTH = 32,
  parameter int unsigned DEPTH = 16
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0] cnt_q;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign in_ready = cnt_q != AW'(0) + (AW+1)'(DEPTH);
  assign out_valid = cnt_q != '0;
  assign out_data = mem_q[rp_q];
  if (DEPTH < 2 || (1 << AW) != DEPTH)
  begin : g_chk
    $error("sfe_fifo depth must be a power of two");
  end
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
      begin
        mem_q[wp_q] <= in_data;
        wp_q <= wp_q + AW'(1);
      end
      if (pop)
        rp_q <= rp_q + AW'(1);
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // sfe_fifo

module sfe_top #(
  parameter int unsigned BLKE_CYC = `SFE_T_BLKE_US * `SFE_CLK_MHZ,
  parameter int unsigned CHPE_CYC = `SFE_T_CHPE_US * `SFE_CLK_MHZ,
  parameter int unsigned PP_CYC = `SFE_T_PP_US * `SFE_CLK_MHZ,
  parameter int unsigned BP_CYC = `SFE_T_BP_US * `SFE_CLK_MHZ,
  parameter int unsigned FIFO_DEPTH = 16
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Serial link pins
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  // Protection inputs
  input wire logic [2:0] block_protect_field,
  input wire logic individual_lock_select,
  input wire logic target_prot,
  // Array side
  input wire logic arr_fail,
  input wire logic wr_ready,
  output logic wr_valid,
  output logic [23:0] wr_addr,
  output logic [7:0] wr_data,
  output logic arr_erase,
  output sfe_pkg::sfe_kind_t arr_kind,
  output logic [23:0] arr_addr,
  output logic [23:0] cmd_addr,
  output logic suspend_req,
  // Status
  output logic [7:0] status_reg_one,
  output logic [1:0] status_reg_four
);
  import sfe_pkg::*;

  localparam int unsigned FW = 32;

  function automatic sfe_kind_t op_kind(input logic [7:0] op);
    if (op == `SFE_OP_BE4) return SFE_K4;
    if (op == `SFE_OP_BE32) return SFE_K32;
    if (op == `SFE_OP_BE64) return SFE_K64;
    return SFE_CHIP;
  endfunction

  function automatic logic [23:0] mask_addr(input sfe_kind_t k, input logic [23:0] a);
    unique case (k)
      SFE_K4: return a & `SFE_MASK_4K;
      SFE_K32: return a & `SFE_MASK_32K;
      SFE_K64: return a & `SFE_MASK_64K;
      SFE_CHIP: return '0;
    endcase
  endfunction

  if (FIFO_DEPTH < 2 || BP_CYC < 1 || PP_CYC < 1 || BLKE_CYC < 1 || CHPE_CYC < 1)
  begin : g_chk
    $error("sfe_top parameters out of range");
  end

  // Link synchronisers and edge detect
  logic [2:0] sck_s;
  logic [2:0] cs_s;
  logic [1:0] si_s;
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      sck_s <= '0;
      cs_s <= 3'h7;
      si_s <= '0;
    end
    else
    begin
      sck_s <= {sck_s[1:0], sck};
      cs_s <= {cs_s[1:0], cs_n};
      si_s <= {si_s[0], si};
    end
  end
  wire sck_rise = sck_s[1] && !sck_s[2] && !cs_s[1];
  wire cs_start = !cs_s[1] && cs_s[2];
  wire cs_end = cs_s[1] && !cs_s[2];

  // Command shifter
  logic [2:0] bit_q;
  logic [9:0] nb_q;
  logic [6:0] sh_q;
  logic [7:0] op_q;
  logic [23:0] addr_q;
  logic [7:0] pbuf_q [256];
  logic [255:0] pmask_q;
  sfe_state_t st_q;
  wire [7:0] byte_w = {sh_q, si_s[1]};
  wire byte_done = sck_rise && bit_q == 3'h7;
  wire idle = st_q == SFE_IDLE;
  wire [7:0] pidx = 8'(addr_q[7:0] + nb_q[7:0] - `SFE_ADDR_END);
  wire data_ph = op_q == `SFE_OP_PP && nb_q >= `SFE_ADDR_END && idle;

  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      bit_q <= '0;
      nb_q <= '0;
      sh_q <= '0;
      op_q <= '0;
      addr_q <= '0;
      pmask_q <= '0;
    end
    else if (cs_start)
    begin
      bit_q <= '0;
      nb_q <= '0;
      if (idle)
        pmask_q <= '0;
    end
    else if (sck_rise)
    begin
      bit_q <= bit_q + 3'h1;
      sh_q <= byte_w[6:0];
      if (byte_done && nb_q != `SFE_NB_MAX)
        nb_q <= nb_q + 10'h001;
      if (byte_done && nb_q == '0)
        op_q <= byte_w;
      if (byte_done && nb_q != '0 && nb_q < `SFE_ADDR_END && idle)
        addr_q <= {addr_q[15:0], byte_w};
      if (byte_done && data_ph)
      begin
        pbuf_q[pidx] <= byte_w;
        pmask_q[pidx] <= 1'b1;
      end
    end
  end

  // Decode at chip select release
  wire has_op = nb_q != '0;
  wire aligned = bit_q == 3'h0;
  wire is_blk = has_op && (op_q == `SFE_OP_BE4 || op_q == `SFE_OP_BE32 || op_q == `SFE_OP_BE64);
  wire is_chip = has_op && (op_q == `SFE_OP_CE_A || op_q == `SFE_OP_CE_B);
  wire is_pp = has_op && op_q == `SFE_OP_PP;
  wire prot_any = |block_protect_field || individual_lock_select;
  logic wel_q;
  wire act = idle && cs_end && wel_q;
  wire go_blk = act && is_blk && aligned && nb_q >= `SFE_ADDR_END && !target_prot;
  wire go_chip = act && is_chip && aligned && !prot_any;
  wire go_pp = act && is_pp && aligned && nb_q >= `SFE_DATA_FIRST && !target_prot;
  wire wel_kill = act && (is_blk || is_chip || is_pp);
  wire wren = idle && cs_end && aligned && nb_q == `SFE_CMD_BYTES && op_q == `SFE_OP_WREN;
  wire wrdi = idle && cs_end && aligned && nb_q == `SFE_CMD_BYTES && op_q == `SFE_OP_WRDI;
  wire susp = !idle && cs_end && aligned && has_op && op_q == `SFE_OP_SUSP
    && !(arr_erase && arr_kind == SFE_CHIP);

  // Sequencer
  logic [31:0] tmr_q;
  logic [8:0] didx_q;
  logic ee_q;
  logic pe_q;
  logic busy_q;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [FW-1:0] fifo_out_data;
  wire drain_done = didx_q == `SFE_PAGE_LAST;
  wire want_push = st_q == SFE_PROG && !drain_done && pmask_q[didx_q[7:0]];
  wire push_ok = want_push && fifo_in_ready;
  wire fifo_out_ready = !wr_valid || wr_ready;
  wire prog_end = st_q == SFE_PROG && drain_done && tmr_q == '0 && !fifo_out_valid && !wr_valid;
  wire erase_end = st_q == SFE_ERASE && tmr_q == '0;

  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      st_q <= SFE_IDLE;
      tmr_q <= '0;
      didx_q <= '0;
      wel_q <= 1'b0;
      busy_q <= 1'b0;
      arr_erase <= 1'b0;
      arr_kind <= SFE_K4;
      arr_addr <= '0;
      suspend_req <= 1'b0;
      ee_q <= 1'b0;
      pe_q <= 1'b0;
    end
    else
    begin
      suspend_req <= susp;
      if (wel_kill || wrdi)
        wel_q <= 1'b0;
      else if (wren)
        wel_q <= 1'b1;
      if (st_q == SFE_ERASE && arr_fail)
      begin
        ee_q <= 1'b1;
        pe_q <= 1'b1;
      end
      else if (go_blk || go_chip || go_pp)
      begin
        ee_q <= 1'b0;
        pe_q <= 1'b0;
      end
      unique case (st_q)
        SFE_IDLE:
          if (go_blk || go_chip)
          begin
            st_q <= SFE_ERASE;
            busy_q <= 1'b1;
            arr_erase <= 1'b1;
            arr_kind <= op_kind(op_q);
            arr_addr <= mask_addr(op_kind(op_q), addr_q);
            tmr_q <= is_chip ? CHPE_CYC - 1 : BLKE_CYC - 1;
          end
          else if (go_pp)
          begin
            st_q <= SFE_PROG;
            busy_q <= 1'b1;
            didx_q <= '0;
            tmr_q <= nb_q == `SFE_DATA_FIRST ? BP_CYC - 1 : PP_CYC - 1;
          end
        SFE_ERASE:
          if (erase_end)
          begin
            st_q <= SFE_IDLE;
            busy_q <= 1'b0;
            arr_erase <= 1'b0;
          end
          else
            tmr_q <= tmr_q - 32'h1;
        SFE_PROG:
        begin
          if (tmr_q != '0)
            tmr_q <= tmr_q - 32'h1;
          if (!drain_done && (push_ok || !want_push))
            didx_q <= didx_q + 9'h001;
          if (prog_end)
          begin
            st_q <= SFE_IDLE;
            busy_q <= 1'b0;
          end
        end
        default:
          st_q <= SFE_IDLE;
      endcase
    end
  end

  sfe_fifo #(.WIDTH(FW), .DEPTH(FIFO_DEPTH)) sfe_fifo_inst (
    .mclk(mclk),
    .nrst(nrst),
    .in_valid(want_push),
    .in_ready(fifo_in_ready),
    .in_data({addr_q[23:8], didx_q[7:0], pbuf_q[didx_q[7:0]]}),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  // Array write port register
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      wr_valid <= 1'b0;
      wr_addr <= '0;
      wr_data <= '0;
      cmd_addr <= '0;
      status_reg_one <= '0;
      status_reg_four <= '0;
    end
    else
    begin
      if (fifo_out_ready)
      begin
        wr_valid <= fifo_out_valid;
        wr_addr <= fifo_out_data[31:8];
        wr_data <= fifo_out_data[7:0];
      end
      cmd_addr <= addr_q;
      status_reg_one <= {3'h0, block_protect_field, wel_q, busy_q};
      status_reg_four <= {ee_q, pe_q};
    end
  end

  // Checks
  property p_busy;
    @(posedge mclk) disable iff (!nrst) st_q == SFE_ERASE |-> status_reg_one[`SFE_BUSY_BIT] || $past(st_q) == SFE_IDLE;
  endproperty
  a_busy: assert property (p_busy) else $error("busy flag low during erase");
  property p_wel_start;
    @(posedge mclk) disable iff (!nrst) $rose(arr_erase) |-> ##1 !status_reg_one[`SFE_WEL_BIT];
  endproperty
  a_wel_start: assert property (p_wel_start) else $error("write enable still set in erase");
  property p_mask4;
    @(posedge mclk) disable iff (!nrst) arr_erase && arr_kind == SFE_K4 |-> arr_addr[11:0] == 12'h000;
  endproperty
  a_mask4: assert property (p_mask4) else $error("4KB erase address not masked");
  property p_partial;
    @(posedge mclk) disable iff (!nrst) cs_end && idle && !aligned && (is_blk || is_chip || is_pp)
      |=> st_q == SFE_IDLE ##1 !status_reg_one[`SFE_WEL_BIT];
  endproperty
  a_partial: assert property (p_partial) else $error("partial byte not aborted");
  property p_short;
    @(posedge mclk) disable iff (!nrst) cs_end && idle && is_blk && nb_q < `SFE_ADDR_END |=> st_q == SFE_IDLE;
  endproperty
  a_short: assert property (p_short) else $error("short address erase started");
  property p_chip_prot;
    @(posedge mclk) disable iff (!nrst) cs_end && idle && is_chip && prot_any |=> !arr_erase;
  endproperty
  a_chip_prot: assert property (p_chip_prot) else $error("chip erase ran while protected");
  property p_nowel;
    @(posedge mclk) disable iff (!nrst) cs_end && idle && !wel_q |=> st_q == SFE_IDLE;
  endproperty
  a_nowel: assert property (p_nowel) else $error("command ran without write enable");
  property p_susp;
    @(posedge mclk) disable iff (!nrst) cs_end && arr_erase && arr_kind == SFE_CHIP |=> !suspend_req;
  endproperty
  a_susp: assert property (p_susp) else $error("suspend during chip erase");
  property p_err;
    @(posedge mclk) disable iff (!nrst) st_q == SFE_ERASE && arr_fail |-> ##2 status_reg_four == 2'h3;
  endproperty
  a_err: assert property (p_err) else $error("erase failure not reported");
  property p_pp_prot;
    @(posedge mclk) disable iff (!nrst) cs_end && idle && is_pp && target_prot |=> st_q == SFE_IDLE;
  endproperty
  a_pp_prot: assert property (p_pp_prot) else $error("program ran on protected page");
endmodule // sfe_top

// ---- tb/sfe_host.sv ----
// Serial link host model, mode 0, 80 ns link clock
`timescale 1ns/100ps
module sfe_host (
  // Clock
  input wire logic mclk,
  // Serial link
  output logic sck,
  output logic cs_n,
  output logic si
);
  logic [7:0] tx [0:299];
  initial
  begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end
  // One frame, MSB first, clock still between frames
  task automatic xfer(input int nb);
    int i;
    @(posedge mclk);
    #1;
    cs_n = 1'b0;
    for (i = 0; i < nb; i++)
    begin
      si = tx[i / 8][7 - (i % 8)];
      #40;
      sck = 1'b1;
      #40;
      sck = 1'b0;
    end
    #40;
    cs_n = 1'b1;
    si = ~si;
    repeat (6) @(posedge mclk);
  endtask
endmodule // sfe_host

// ---- tb/tb_sfe_top.sv ----
// Testbench for the serial flash erase/program sequencer
`timescale 1ns/100ps
module tb_sfe_top;
  import sfe_pkg::*;
  logic mclk, nrst, sck, cs_n, si, ils, tprot, afail, wrdy, wr_valid, arr_erase, suspend_req, e_prev;
  logic [2:0] bp;
  logic [7:0] wr_data, status_reg_one;
  logic [7:0] pmem [0:255];
  logic [7:0] xmem [0:255];
  int pit [0:255];
  logic [23:0] wr_addr, arr_addr, cmd_addr;
  logic [15:0] pg;
  logic [1:0] status_reg_four;
  sfe_kind_t arr_kind;
  int err_total, check_count, e_cnt, s_cnt, wn, i, k, e0, w0;
  logic [7:0] bop [0:2] = '{8'h20, 8'h52, 8'hD8};
  logic [23:0] bad [0:2] = '{24'h12F000, 24'h128000, 24'h120000};
  logic [7:0] rop [0:7] = '{8'h20, 8'h20, 8'h20, 8'h60, 8'h60, 8'h02, 8'h02, 8'h02};
  int rnb [0:7] = '{32, 31, 24, 8, 8, 32, 43, 40};
  logic [2:0] rbp [0:7] = '{3'h0, 3'h0, 3'h0, 3'h4, 3'h0, 3'h0, 3'h0, 3'h0};
  logic [7:0] rils = 8'h10;
  logic [7:0] rtp = 8'h81;
  logic [23:0] pad [0:2] = '{24'h0001F0, 24'h0000FE, 24'h000200};
  int pnd [0:2] = '{20, 3, 258};
  sfe_host host_inst (.mclk(mclk), .sck(sck), .cs_n(cs_n), .si(si));
  sfe_top #(.BLKE_CYC(200), .CHPE_CYC(400), .PP_CYC(10), .BP_CYC(5), .FIFO_DEPTH(16)) sfe_top_inst (
    .mclk(mclk), .nrst(nrst), .sck(sck), .cs_n(cs_n), .si(si), .block_protect_field(bp),
    .individual_lock_select(ils), .target_prot(tprot), .arr_fail(afail), .wr_ready(wrdy),
    .wr_valid(wr_valid), .wr_addr(wr_addr), .wr_data(wr_data), .arr_erase(arr_erase), .arr_kind(arr_kind),
    .arr_addr(arr_addr), .cmd_addr(cmd_addr), .suspend_req(suspend_req), .status_reg_one(status_reg_one),
    .status_reg_four(status_reg_four));
  always #4 mclk = ~mclk;
  // Event counters and array write log
  always @(posedge mclk)
  begin
    e_prev <= arr_erase;
    if (arr_erase === 1'b1 && e_prev !== 1'b1)
      e_cnt++;
    if (suspend_req === 1'b1)
      s_cnt++;
    if (wr_valid === 1'b1 && wrdy === 1'b1)
    begin
      pmem[wr_addr[7:0]] = wr_data;
      pit[wr_addr[7:0]] = i + 1;
      pg = wr_addr[23:8];
      wn++;
    end
  end
  task automatic check(input string nm, input logic [23:0] seen, input logic [23:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  function automatic logic [7:0] dat(input int n);
    return {n[8] ^ n[7], n[6:0]};
  endfunction
  task automatic send(input logic [7:0] op, input logic [23:0] a, input int nd, input int nb);
    int j;
    host_inst.tx[0] = op;
    host_inst.tx[1] = a[23:16];
    host_inst.tx[2] = a[15:8];
    host_inst.tx[3] = a[7:0];
    for (j = 0; j < nd; j++)
      host_inst.tx[4 + j] = dat(j);
    host_inst.xfer(nb);
    repeat (4) @(posedge mclk);
    #1;
  endtask
  task automatic wen;
    send(8'h06, 24'h0, 0, 8);
    check("wel", status_reg_one[1], 1'b1);
  endtask
  task automatic idle;
    int n;
    n = 0;
    while (status_reg_one[0] !== 1'b0 && n < 5000)
    begin
      @(posedge mclk);
      n++;
    end
    #1;
    check("idle", n < 5000, 1'b1);
  endtask
  initial
  begin
    mclk = 1'b0;
    nrst = 1'b0;
    bp = 3'h0;
    ils = 1'b0;
    tprot = 1'b0;
    afail = 1'b0;
    wrdy = 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    nrst = 1'b1;
    repeat (6) @(posedge mclk);
    #1;
    check("sr1", status_reg_one, 8'h00);
    check("erase", arr_erase, 1'b0);
    send(8'h20, 24'h12FABC, 0, 32);
    check("no wel", e_cnt, 0);
    wen();
    send(8'h04, 24'h0, 0, 8);
    check("wrdi", status_reg_one[1], 1'b0);
    send(8'h20, 24'h12FABC, 0, 32);
    check("no wel", e_cnt, 0);
    $display("test reset done");
    for (i = 0; i < 3; i++)
    begin
      wen();
      send(bop[i], 24'h12FABC, 0, 32);
      check("run", arr_erase, 1'b1);
      check("kind", arr_kind, i);
      check("base", arr_addr, bad[i]);
      check("cmd", cmd_addr, 24'h12FABC);
      check("sr1", status_reg_one[1:0], 2'b01);
      send(8'h75, 24'h0, 0, 8);
      check("susp", s_cnt, i + 1);
      idle();
    end
    for (i = 0; i < 2; i++)
    begin
      wen();
      send(i ? 8'hC7 : 8'h60, 24'h0, 0, 8);
      check("chip", {arr_erase, arr_kind}, 3'h7);
      check("base", arr_addr, 24'h0);
      send(8'h75, 24'h0, 0, 8);
      check("susp", s_cnt, 3);
      idle();
    end
    wen();
    afail = 1'b1;
    send(8'h20, 24'h0, 0, 32);
    idle();
    check("sr4", status_reg_four, 2'h3);
    afail = 1'b0;
    $display("test erase done");
    for (i = 0; i < 8; i++)
    begin
      bp = rbp[i];
      ils = rils[i];
      tprot = rtp[i];
      wen();
      e0 = e_cnt;
      w0 = wn;
      send(rop[i], 24'h000100, 2, rnb[i]);
      repeat (30) @(posedge mclk);
      #1;
      check("refused", e_cnt + wn - e0 - w0, 0);
      check("wel", status_reg_one[1:0], 2'b00);
      check("bp", status_reg_one[4:2], rbp[i]);
    end
    bp = 3'h0;
    ils = 1'b0;
    tprot = 1'b0;
    $display("test refuse done");
    for (i = 0; i < 3; i++)
    begin
      for (k = 0; k < 256; k++)
        xmem[k] = 8'hFF;
      for (k = 0; k < pnd[i]; k++)
        xmem[8'(pad[i] + k)] = dat(k);
      w0 = wn;
      wrdy = (i != 0);
      wen();
      send(8'h02, pad[i], pnd[i], 32 + 8 * pnd[i]);
      if (i == 0)
      begin
        repeat (100) @(posedge mclk);
        #1;
        check("stall", {wr_valid, status_reg_one[0]}, 2'h3);
        wrdy = 1'b1;
      end
      idle();
      check("count", wn - w0, pnd[i] > 256 ? 256 : pnd[i]);
      check("page", pg, pad[i][23:8]);
      for (k = 0; k < 256; k++)
        check("byte", pit[k] == i + 1 ? pmem[k] : 8'hFF, xmem[k]);
    end
    $display("test program done");
    results();
  end
  initial
  begin
    #600000;
    err_total++;
    results();
  end
endmodule // tb_sfe_top
